// *** hdl/pcr_match.sv ***
// Comparator of one module against the counter with cycle length masking.
`timescale 1ns/100ps
`default_nettype none
module pcr_match (
  input  wire logic [15:0] count_val,
  input  wire logic [15:0] compare_val,
  input  wire logic        enable,
  input  wire logic        wide_pwm,
  input  wire logic [1:0]  cycle_len,
  output logic             hit
);
  logic [15:0] mask;

  // A wide module compares all bits; otherwise the cycle length picks 8 to 11.
  always_comb begin
    if (wide_pwm) begin
      mask = 16'hffff;
    end else begin
      case (cycle_len)
        pcr_pkg::CYCLE_LENGTH_FIELD_8:  mask = 16'h00ff;
        pcr_pkg::CYCLE_LENGTH_FIELD_9:  mask = 16'h01ff;
        pcr_pkg::CYCLE_LENGTH_FIELD_10: mask = 16'h03ff;
        default:           mask = 16'h07ff;
      endcase
    end
  end

  assign hit = enable && ((count_val & mask) == (compare_val & mask));
endmodule
`default_nettype wire

// *** hdl/pcr_pkg.sv ***
// Package holding offsets, field positions and reset values of the counter array registers.
package pcr_pkg;
  localparam int unsigned NUM_MODULES = 6;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'hf9;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'hfa;
  localparam logic [7:0] ADDR_PWM_CFG  = 8'hd9;
  localparam logic [7:0] ADDR_MD       = 8'hd8;
  localparam logic [7:0] ADDR_M5_MODE  = 8'hce;
  localparam logic [7:0] ADDR_CP_LOW [0:5] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
  localparam logic [7:0] ADDR_CP_HIGH[0:5] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};
  localparam logic [7:0] ADDR_MODE   [0:5] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hce};
  localparam int unsigned MODE_WIDE_BIT = 7;
  localparam int unsigned MODE_ECOM_BIT = 6;
  localparam int unsigned MODE_PWM_BIT  = 1;
  localparam int unsigned PWM_AUTORELOAD_SELECT_BIT = 7;
  localparam int unsigned MD_WATCHDOG_ENABLE_BIT_BIT   = 6;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] RESET_MD    = 8'h40;
  localparam logic [1:0] CYCLE_LENGTH_FIELD_8     = 2'h0;
  localparam logic [1:0] CYCLE_LENGTH_FIELD_9     = 2'h1;
  localparam logic [1:0] CYCLE_LENGTH_FIELD_10    = 2'h2;
endpackage

// *** hdl/pcr_regs.sv ***
// Counter and capture/compare register file of the programmable counter array.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - A 16-bit counter whose low byte is readable, writable and resets to zero.
// - High byte reads return a snapshot loaded only when the low byte is read.
// - Low byte writes are ignored while the watchdog enable bit is one.
// - High byte writes are ignored while the watchdog enable bit is one.
// - Six modules each hold a 16-bit compare value in low and high bytes.
// - The same addresses also reach each module's auto-reload value.
// - The auto-reload select bit steers module compare byte accesses to reload values.
// - Writing a module low compare byte clears its comparator enable.
// - Writing a module high compare byte sets its comparator enable.
// - A set comparator enable lets that module compare against the counter.
// - With watchdog enabled, module five's mode register is write protected.
// - Cycle length field picks 8, 9, 10 or 11 bits for narrow PWM.
module pcr_regs #(
  parameter int unsigned MODULES = pcr_pkg::NUM_MODULES
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic               count_tick,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic [7:0]         sfr_wdata,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  output logic      [7:0]         sfr_rdata,
  output logic      [MODULES-1:0] match_hit,
  output logic                    watchdog_active
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0]  snap_q;
  logic [7:0]  pwm_cfg_q;
  logic [7:0]  md_q;
  logic [15:0] cp_q     [MODULES];
  logic [15:0] reload_q [MODULES];
  logic [7:0]  mode_q   [MODULES];
  logic [7:0]  rdata_d;
  logic [MODULES-1:0] hit_low;
  logic [MODULES-1:0] hit_high;
  logic [MODULES-1:0] hit_mode;

  wire watchdog_enable_bit     = md_q[pcr_pkg::MD_WATCHDOG_ENABLE_BIT_BIT];
  wire autoreload_select    = pwm_cfg_q[pcr_pkg::PWM_AUTORELOAD_SELECT_BIT];
  wire wr_low   = sfr_wr && (sfr_addr == pcr_pkg::ADDR_CNT_LOW) && !watchdog_enable_bit;
  wire wr_high  = sfr_wr && (sfr_addr == pcr_pkg::ADDR_CNT_HIGH) && !watchdog_enable_bit;
  wire rd_low   = sfr_rd && (sfr_addr == pcr_pkg::ADDR_CNT_LOW);
  wire wr_pwm   = sfr_wr && (sfr_addr == pcr_pkg::ADDR_PWM_CFG);
  wire wr_md    = sfr_wr && (sfr_addr == pcr_pkg::ADDR_MD);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode of the per-module bytes.
  genvar g;
  generate
    for (g = 0; g < MODULES; g++) begin : g_dec
      assign hit_low[g]  = (sfr_addr == pcr_pkg::ADDR_CP_LOW[g]);
      assign hit_high[g] = (sfr_addr == pcr_pkg::ADDR_CP_HIGH[g]);
      assign hit_mode[g] = (sfr_addr == pcr_pkg::ADDR_MODE[g]);
      pcr_match u_match (
        .count_val   (count_q),
        .compare_val (cp_q[g]),
        .enable      (mode_q[g][pcr_pkg::MODE_ECOM_BIT]),
        .wide_pwm    (mode_q[g][pcr_pkg::MODE_WIDE_BIT]),
        .cycle_len   (pwm_cfg_q[1:0]),
        .hit         (match_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Counter: software byte writes override the tick in the same cycle.
  always_comb begin
    count_d = count_q;
    if (count_tick) begin
      count_d = count_q + 16'h0001;
    end
    if (wr_low) begin
      count_d[7:0] = sfr_wdata;
    end
    if (wr_high) begin
      count_d[15:8] = sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q   <= 16'h0000;
      snap_q    <= pcr_pkg::RESET_BYTE;
      pwm_cfg_q <= pcr_pkg::RESET_BYTE;
      md_q      <= pcr_pkg::RESET_MD;
    end else if (clk_en) begin
      count_q <= count_d;
      if (rd_low) begin
        snap_q <= count_q[15:8];
      end
      if (wr_pwm) begin
        pwm_cfg_q <= sfr_wdata;
      end
      if (wr_md) begin
        md_q <= sfr_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Module registers; the select bit aliases compare and reload storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < MODULES; i++) begin
        cp_q[i]     <= 16'h0000;
        reload_q[i] <= 16'h0000;
        mode_q[i]   <= pcr_pkg::RESET_BYTE;
      end
    end else if (clk_en && sfr_wr) begin
      for (int i = 0; i < MODULES; i++) begin
        if (hit_low[i]) begin
          if (autoreload_select) begin
            reload_q[i][7:0] <= sfr_wdata;
          end else begin
            cp_q[i][7:0] <= sfr_wdata;
            mode_q[i][pcr_pkg::MODE_ECOM_BIT] <= 1'b0;
          end
        end
        if (hit_high[i]) begin
          if (autoreload_select) begin
            reload_q[i][15:8] <= sfr_wdata;
          end else begin
            cp_q[i][15:8] <= sfr_wdata;
            mode_q[i][pcr_pkg::MODE_ECOM_BIT] <= 1'b1;
          end
        end
        // Module five is guarded because it is the watchdog while enabled.
        if (hit_mode[i] && !(i == MODULES - 1 && watchdog_enable_bit)) begin
          mode_q[i] <= sfr_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux.
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_addr == pcr_pkg::ADDR_CNT_LOW) rdata_d = count_q[7:0];
    if (sfr_addr == pcr_pkg::ADDR_CNT_HIGH) rdata_d = snap_q;
    if (sfr_addr == pcr_pkg::ADDR_PWM_CFG) rdata_d = pwm_cfg_q;
    if (sfr_addr == pcr_pkg::ADDR_MD) rdata_d = md_q;
    for (int i = 0; i < MODULES; i++) begin
      if (hit_low[i]) rdata_d = autoreload_select ? reload_q[i][7:0] : cp_q[i][7:0];
      if (hit_high[i]) rdata_d = autoreload_select ? reload_q[i][15:8] : cp_q[i][15:8];
      if (hit_mode[i]) rdata_d = mode_q[i];
    end
  end

  assign sfr_rdata = rdata_d;
  assign watchdog_active = watchdog_enable_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  wire [15:0] m0_cp = cp_q[0];

  cnt_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && sfr_addr == pcr_pkg::ADDR_CNT_LOW && watchdog_enable_bit && !count_tick)
      |=> count_q[7:0] == $past(count_q[7:0]))
    else $error("Counter low byte changed while locked.");
  hi_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && sfr_addr == pcr_pkg::ADDR_CNT_HIGH && watchdog_enable_bit && !count_tick)
      |=> count_q[15:8] == $past(count_q[15:8]))
    else $error("Counter high byte changed while locked.");
  snap_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && rd_low) |=> snap_q == $past(count_q[15:8]))
    else $error("Snapshot not loaded on low byte read.");
  snap_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(clk_en && rd_low) |=> $stable(snap_q))
    else $error("Snapshot changed without low byte read.");
  cnt_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && count_tick && !wr_low && !wr_high) |=> count_q == $past(count_q) + 16'h0001)
    else $error("Counter did not increment.");
  cnt_win_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && wr_low) |=> count_q[7:0] == $past(sfr_wdata))
    else $error("Software write lost to tick.");
  ecom_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && !autoreload_select && hit_low[0]) |=> !mode_q[0][pcr_pkg::MODE_ECOM_BIT])
    else $error("Low byte write did not clear enable.");
  ecom_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && !autoreload_select && hit_high[0]) |=> mode_q[0][pcr_pkg::MODE_ECOM_BIT])
    else $error("High byte write did not set enable.");
  alias_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && autoreload_select && hit_low[0]) |=> $stable(m0_cp))
    else $error("Reload write altered compare value.");
  m5_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && hit_mode[MODULES-1] && watchdog_enable_bit) |=> $stable(mode_q[MODULES-1]))
    else $error("Module five mode changed under watchdog.");
  low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sfr_addr == pcr_pkg::ADDR_CNT_LOW) |-> sfr_rdata == count_q[7:0])
    else $error("Counter low byte read wrong.");
  snap_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sfr_addr == pcr_pkg::ADDR_CNT_HIGH) |-> sfr_rdata == snap_q)
    else $error("High byte read did not return snapshot.");
  cp_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && !autoreload_select && hit_low[0]) |=> cp_q[0][7:0] == $past(sfr_wdata))
    else $error("Compare low byte write lost.");
  reload_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && sfr_wr && autoreload_select && hit_low[0]) |=> reload_q[0][7:0] == $past(sfr_wdata))
    else $error("Reload low byte write lost.");
  hit_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !mode_q[0][pcr_pkg::MODE_ECOM_BIT] |-> !match_hit[0])
    else $error("Match raised with comparator disabled.");
  freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(count_q))
    else $error("Counter moved while clock enable low.");
endmodule
`default_nettype wire

// *** tb/pcr_regs_tb.sv ***
// Self-checking testbench for the counter array register file.
`timescale 1ns/100ps
`default_nettype none
module pcr_regs_tb;
  logic       clk;
  logic       sys_rst;
  logic       clk_en;
  logic       count_tick;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic [5:0] match_hit;
  logic       watchdog_active;
  logic [7:0] exp_q[$];
  logic       chk;
  logic [7:0] rv;
  int         error_cnt;
  int         n_checks;
  int         cycles;

  pcr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .count_tick(count_tick),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .match_hit(match_hit), .watchdog_active(watchdog_active));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A read notes its expected byte; the strobes are left up so back to back
  // accesses never assign a strobe twice in one time step.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_wr = w;
    sfr_rd = !w;
    chk = !w;
    sfr_addr = a;
    sfr_wdata = d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    chk = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Read data is combinational, so it is looked at mid-cycle when settled.
  always @(negedge clk) begin
    if (chk === 1'b1) check(sfr_rdata, exp_q.pop_front());
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("FAIL %0t: timeout", $time);
      conclude();
    end
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    count_tick = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    chk = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    rv = 8'($urandom(32'h9003));
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check({7'h00, watchdog_active}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, pcr_pkg::ADDR_CP_LOW[i], 8'h00);
      acc(1'b0, pcr_pkg::ADDR_CP_HIGH[i], 8'h00);
    end
    acc(1'b0, 8'h80, 8'h00);
    acc(1'b1, pcr_pkg::ADDR_CNT_LOW, 8'h5a);
    acc(1'b1, pcr_pkg::ADDR_CNT_HIGH, 8'ha5);
    acc(1'b0, pcr_pkg::ADDR_CNT_LOW, 8'h00);
    acc(1'b0, pcr_pkg::ADDR_CNT_HIGH, 8'h00);
    acc(1'b1, pcr_pkg::ADDR_MD, 8'h00);
    check({7'h00, watchdog_active}, 8'h00);
    acc(1'b1, pcr_pkg::ADDR_CNT_HIGH, 8'h12);
    acc(1'b1, pcr_pkg::ADDR_CNT_LOW, 8'hfe);
    acc(1'b0, pcr_pkg::ADDR_CNT_LOW, 8'hfe);
    count_tick = 1'b1;
    idle(3);
    count_tick = 1'b0;
    acc(1'b0, pcr_pkg::ADDR_CNT_HIGH, 8'h12);
    acc(1'b0, pcr_pkg::ADDR_CNT_LOW, 8'h01);
    acc(1'b0, pcr_pkg::ADDR_CNT_HIGH, 8'h13);
    count_tick = 1'b1;
    acc(1'b1, pcr_pkg::ADDR_CNT_LOW, 8'h10);
    count_tick = 1'b0;
    acc(1'b0, pcr_pkg::ADDR_CNT_LOW, 8'h10);
    acc(1'b0, pcr_pkg::ADDR_CNT_HIGH, 8'h13);
    for (int i = 0; i < 6; i++) begin
      rv = 8'($urandom);
      acc(1'b1, pcr_pkg::ADDR_CP_HIGH[i], rv);
      acc(1'b0, pcr_pkg::ADDR_MODE[i], 8'h40);
      acc(1'b1, pcr_pkg::ADDR_CP_LOW[i], ~rv);
      acc(1'b0, pcr_pkg::ADDR_MODE[i], 8'h00);
      acc(1'b0, pcr_pkg::ADDR_CP_HIGH[i], rv);
      acc(1'b0, pcr_pkg::ADDR_CP_LOW[i], ~rv);
    end
    acc(1'b1, pcr_pkg::ADDR_CP_LOW[0], 8'h10);
    acc(1'b1, pcr_pkg::ADDR_CP_HIGH[0], 8'h13);
    acc(1'b1, pcr_pkg::ADDR_MODE[0], 8'hc0);
    check({2'h0, match_hit}, 8'h01);
    acc(1'b1, pcr_pkg::ADDR_MODE[0], 8'h80);
    check({2'h0, match_hit}, 8'h00);
    acc(1'b1, pcr_pkg::ADDR_CP_HIGH[0], 8'h00);
    acc(1'b1, pcr_pkg::ADDR_MODE[0], 8'h40);
    check({2'h0, match_hit}, 8'h01);
    acc(1'b1, pcr_pkg::ADDR_PWM_CFG, 8'h01);
    check({2'h0, match_hit}, 8'h00);
    acc(1'b1, pcr_pkg::ADDR_CP_HIGH[1], 8'h77);
    acc(1'b1, pcr_pkg::ADDR_PWM_CFG, 8'h80);
    acc(1'b1, pcr_pkg::ADDR_CP_HIGH[1], 8'h3c);
    acc(1'b0, pcr_pkg::ADDR_CP_HIGH[1], 8'h3c);
    acc(1'b0, pcr_pkg::ADDR_MODE[1], 8'h40);
    acc(1'b1, pcr_pkg::ADDR_CP_LOW[0], 8'h6b);
    acc(1'b0, pcr_pkg::ADDR_CP_LOW[0], 8'h6b);
    acc(1'b1, pcr_pkg::ADDR_PWM_CFG, 8'h00);
    acc(1'b0, pcr_pkg::ADDR_CP_HIGH[1], 8'h77);
    acc(1'b0, pcr_pkg::ADDR_CP_LOW[0], 8'h10);
    acc(1'b1, pcr_pkg::ADDR_MD, 8'h40);
    acc(1'b1, pcr_pkg::ADDR_MODE[5], 8'hff);
    acc(1'b0, pcr_pkg::ADDR_MODE[5], 8'h00);
    acc(1'b1, pcr_pkg::ADDR_CNT_LOW, 8'h99);
    acc(1'b0, pcr_pkg::ADDR_CNT_LOW, 8'h10);
    idle(2);
    conclude();
  end
endmodule
`default_nettype wire
